// ==== rscp_cfg.svh ====
// Constants of the receiver serial configuration port
// Assumes a 100 MHz system clock; included by the package and the port
`ifndef RSCP_CFG_SVH
`define RSCP_CFG_SVH

`define RSCP_CFG_WIDTH 20
`define RSCP_CFG_RESET 20'h00000
`define RSCP_CNT_FULL 5'h14
`define RSCP_DES_MSB 2
`define RSCP_DES_LSB 0
`define RSCP_BW_MSB 4
`define RSCP_BW_LSB 3
`define RSCP_SLICE_MSB 6
`define RSCP_SLICE_LSB 5
`define RSCP_CHK_MSB 8
`define RSCP_CHK_LSB 7
`define RSCP_WIN_MSB 11
`define RSCP_WIN_LSB 9
`define RSCP_SLEEP_MSB 14
`define RSCP_SLEEP_LSB 12
`define RSCP_AUTOPOLL_BIT 15
`define RSCP_HIBW_BIT 16
`define RSCP_SQUELCH_BIT 17
`define RSCP_WDOG_BIT 18
`define RSCP_RSSI_BIT 19

`define RSCP_NPIN 6
`define RSCP_PIN_SCLK 0
`define RSCP_PIN_DATA 1
`define RSCP_PIN_PD 2
`define RSCP_PIN_BWLO 3
`define RSCP_PIN_BWHI 4
`define RSCP_PIN_SQ 5

`define RSCP_CLK_PERIOD_NS 10
`define RSCP_STARTUP_US 1000
`define RSCP_STARTUP_MAX_US 2000
`define RSCP_STARTUP_CYC ((`RSCP_STARTUP_US * 1000) / `RSCP_CLK_PERIOD_NS)
`define RSCP_STARTUP_MAX_CYC ((`RSCP_STARTUP_MAX_US * 1000) / `RSCP_CLK_PERIOD_NS)
`define RSCP_STARTUP_CW 17

`endif

// ==== rscp_pkg.sv ====
// Types of the receiver serial configuration port
// Assumes rscp_cfg.svh is on the include path
`include "rscp_cfg.svh"

package rscp_pkg;
   typedef logic [`RSCP_CFG_WIDTH-1:0] rscp_word_t;
   typedef logic [`RSCP_NPIN-1:0] rscp_pins_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_OPEN_CLK_LO = 3'h1,
      ST_OPEN_CLK_HI = 3'h2,
      ST_OPEN_DAT_HI = 3'h3,
      ST_OPEN_DAT_LO = 3'h4,
      ST_SHIFT = 3'h5,
      ST_STOP_DAT_HI = 3'h6,
      ST_STOP_DAT_LO = 3'h7
   } rscp_state_t;
endpackage

// ==== rscp_pin_if.sv ====
// Carries raw pin levels into the synchroniser and clean levels and edges out
// Assumes both ends run on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "rscp_cfg.svh"

interface rscp_pin_if;
   logic [`RSCP_NPIN-1:0] raw;
   logic [`RSCP_NPIN-1:0] lvl;
   logic [`RSCP_NPIN-1:0] rise;
   logic [`RSCP_NPIN-1:0] fall;
   modport sync (input raw, output lvl, output rise, output fall);
   modport user (output raw, input lvl, input rise, input fall);
endinterface

`default_nettype wire

// ==== rscp_sync.sv ====
// Two-flop synchroniser with edge detect for the external pins
// Assumes pins are asynchronous to clk_sys_in
`timescale 1ns/1ps
`default_nettype none

module rscp_sync
   import rscp_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   rscp_pin_if.sync pins
);
   rscp_pins_t meta_q, meta_d;
   rscp_pins_t lvl_q, lvl_d;
   rscp_pins_t old_q, old_d;

   always_comb begin
      meta_d = clk_en_in ? pins.raw : meta_q;
      lvl_d = clk_en_in ? meta_q : lvl_q;
      old_d = clk_en_in ? lvl_q : old_q;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         meta_q <= '0;
         lvl_q <= '0;
         old_q <= '0;
      end else begin
         meta_q <= meta_d;
         lvl_q <= lvl_d;
         old_q <= old_d;
      end
   end

   assign pins.lvl = lvl_q;
   assign pins.rise = lvl_q & ~old_q;
   assign pins.fall = ~lvl_q & old_q;
endmodule

`default_nettype wire

// ==== rscp_port.sv ====
// Receiver serial configuration port: two-pin session decoder and config word
// Assumes rx_data_in and signal_valid_in come from the demodulator on clk_sys_in
`timescale 1ns/1ps
`default_nettype none
`include "rscp_cfg.svh"

module rscp_port
   import rscp_pkg::*;
#(
   parameter int STARTUP_CYCLES = `RSCP_STARTUP_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic sclk_in,
   input wire logic data_pin_in,
   output logic data_pin_out,
   output logic data_pin_oe_n_out,
   input wire logic power_down_pin_in,
   input wire logic bw_select_lo_in,
   input wire logic bw_select_hi_in,
   input wire logic squelch_select_in,
   input wire logic rx_data_in,
   input wire logic signal_valid_in,
   output logic prog_mode_out,
   output logic cfg_loaded_out,
   output logic operational_out,
   output logic [2:0] desense_out,
   output logic [1:0] demod_bw_out,
   output logic [1:0] slice_level_out,
   output logic [1:0] bit_check_out,
   output logic [2:0] window_out,
   output logic [2:0] sleep_time_out,
   output logic autopoll_out,
   output logic high_bw_out,
   output logic squelch_on_out,
   output logic watchdog_off_out,
   output logic rssi_offset_out
);
   rscp_pin_if pins ();

   assign pins.raw = {squelch_select_in, bw_select_hi_in, bw_select_lo_in,
                      power_down_pin_in, data_pin_in, sclk_in};

   rscp_sync u_sync (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .pins(pins)
   );

   logic sclk_hi, sclk_rise, sclk_fall, dat_hi, dat_rise, dat_fall, pd_hi;
   assign sclk_hi = pins.lvl[`RSCP_PIN_SCLK];
   assign sclk_rise = pins.rise[`RSCP_PIN_SCLK];
   assign sclk_fall = pins.fall[`RSCP_PIN_SCLK];
   assign dat_hi = pins.lvl[`RSCP_PIN_DATA];
   assign dat_rise = pins.rise[`RSCP_PIN_DATA];
   assign dat_fall = pins.fall[`RSCP_PIN_DATA];
   assign pd_hi = pins.lvl[`RSCP_PIN_PD];

   // Session decoder
   rscp_state_t state_q, state_d;
   rscp_word_t shift_q, shift_d;
   rscp_word_t word_q, word_d;
   logic [4:0] cnt_q, cnt_d;
   logic loaded_q, loaded_d;
   logic sample, commit;

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      word_d = word_q;
      cnt_d = cnt_q;
      loaded_d = loaded_q;
      sample = 1'b0;
      commit = 1'b0;
      if (clk_en_in) begin
         case (state_q)
            ST_IDLE: begin
               // A rise, not a level, so a clock left high after an abort does not reopen
               if (sclk_rise) begin
                  state_d = ST_OPEN_CLK_LO;
               end
            end
            ST_OPEN_CLK_LO: begin
               if (sclk_fall) begin
                  state_d = dat_hi ? ST_IDLE : ST_OPEN_CLK_HI;
               end
            end
            ST_OPEN_CLK_HI: begin
               if (sclk_rise) begin
                  state_d = dat_hi ? ST_IDLE : ST_OPEN_DAT_HI;
               end
            end
            ST_OPEN_DAT_HI: begin
               if (sclk_fall) begin
                  state_d = ST_IDLE;
               end else if (dat_rise) begin
                  state_d = ST_OPEN_DAT_LO;
               end
            end
            ST_OPEN_DAT_LO: begin
               if (sclk_fall) begin
                  state_d = ST_IDLE;
               end else if (dat_fall) begin
                  state_d = ST_SHIFT;
                  cnt_d = 5'h00;
               end
            end
            ST_SHIFT: begin
               if (sclk_rise) begin
                  sample = 1'b1;
                  shift_d = {shift_q[`RSCP_CFG_WIDTH-2:0], dat_hi};
                  cnt_d = (cnt_q == `RSCP_CNT_FULL) ? cnt_q : cnt_q + 5'h01;
               end else if (sclk_hi && dat_rise) begin
                  state_d = ST_STOP_DAT_HI;
               end
            end
            ST_STOP_DAT_HI: begin
               if (sclk_fall) begin
                  state_d = ST_SHIFT;
               end else if (dat_fall) begin
                  state_d = ST_STOP_DAT_LO;
               end
            end
            ST_STOP_DAT_LO: begin
               if (sclk_fall) begin
                  commit = 1'b1;
                  state_d = ST_IDLE;
                  loaded_d = 1'b1;
                  for (int i = 0; i < `RSCP_CFG_WIDTH; i++) begin
                     if (i < int'(cnt_q)) begin
                        word_d[i] = shift_q[i];
                     end
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
         shift_q <= '0;
         word_q <= `RSCP_CFG_RESET;
         cnt_q <= 5'h00;
         loaded_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         word_q <= word_d;
         cnt_q <= cnt_d;
         loaded_q <= loaded_d;
      end
   end

   // Field decode and pin override
   logic [1:0] bw_q, bw_d;
   logic sq_q, sq_d;

   always_comb begin
      bw_q_hold: begin
         bw_d = bw_q;
         sq_d = sq_q;
      end
      if (clk_en_in) begin
         if (loaded_q) begin
            bw_d = word_q[`RSCP_BW_MSB:`RSCP_BW_LSB];
            sq_d = word_q[`RSCP_SQUELCH_BIT];
         end else begin
            bw_d = {pins.lvl[`RSCP_PIN_BWHI], pins.lvl[`RSCP_PIN_BWLO]};
            sq_d = ~pins.lvl[`RSCP_PIN_SQ];
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         bw_q <= 2'h0;
         sq_q <= 1'b0;
      end else begin
         bw_q <= bw_d;
         sq_q <= sq_d;
      end
   end

   assign desense_out = word_q[`RSCP_DES_MSB:`RSCP_DES_LSB];
   assign demod_bw_out = bw_q;
   assign slice_level_out = word_q[`RSCP_SLICE_MSB:`RSCP_SLICE_LSB];
   assign bit_check_out = word_q[`RSCP_CHK_MSB:`RSCP_CHK_LSB];
   assign window_out = word_q[`RSCP_WIN_MSB:`RSCP_WIN_LSB];
   assign sleep_time_out = word_q[`RSCP_SLEEP_MSB:`RSCP_SLEEP_LSB];
   assign autopoll_out = word_q[`RSCP_AUTOPOLL_BIT];
   assign high_bw_out = word_q[`RSCP_HIBW_BIT];
   assign squelch_on_out = sq_q;
   assign watchdog_off_out = word_q[`RSCP_WDOG_BIT];
   assign rssi_offset_out = word_q[`RSCP_RSSI_BIT];
   assign cfg_loaded_out = loaded_q;
   assign prog_mode_out = (state_q != ST_IDLE);

   // Shutdown, startup delay, wake and data output
   logic [`RSCP_STARTUP_CW-1:0] start_q, start_d;
   logic oper_q, oper_d;
   logic woken_q, woken_d;
   logic dout_q, dout_d;

   always_comb begin
      start_d = start_q;
      oper_d = oper_q;
      woken_d = woken_q;
      dout_d = dout_q;
      if (clk_en_in) begin
         if (pd_hi) begin
            start_d = '0;
            oper_d = 1'b0;
         end else if (start_q == `RSCP_STARTUP_CW'(STARTUP_CYCLES)) begin
            oper_d = 1'b1;
         end else begin
            start_d = start_q + `RSCP_STARTUP_CW'(1);
         end
         if (!oper_q || !autopoll_out) begin
            woken_d = 1'b0;
         end else if (signal_valid_in) begin
            woken_d = 1'b1;
         end
         if (!oper_q || (autopoll_out && !woken_q)) begin
            dout_d = 1'b0;
         end else if (sq_q) begin
            dout_d = rx_data_in & signal_valid_in;
         end else begin
            dout_d = rx_data_in;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         start_q <= '0;
         oper_q <= 1'b0;
         woken_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         start_q <= start_d;
         oper_q <= oper_d;
         woken_q <= woken_d;
         dout_q <= dout_d;
      end
   end

   assign operational_out = oper_q;
   assign data_pin_out = dout_q;
   assign data_pin_oe_n_out = sclk_hi || (state_q != ST_IDLE);

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   logic [`RSCP_STARTUP_CW:0] low_run_q;
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || pd_hi) begin
         low_run_q <= '0;
      end else if (clk_en_in && !low_run_q[`RSCP_STARTUP_CW]) begin
         low_run_q <= low_run_q + 1'b1;
      end
   end

   pin_release_a: assert property (sclk_hi |-> data_pin_oe_n_out)
      else $error("data pin driven while serial clock high");
   close_exit_a: assert property (commit |=> state_q == ST_IDLE && loaded_q
      && (sclk_hi || !data_pin_oe_n_out))
      else $error("close sequence did not return to driving");
   msb_order_a: assert property (sample |=> shift_q[0] == $past(dat_hi)
      && shift_q[19:1] == $past(shift_q[18:0]))
      else $error("bit not shifted in at the bottom");
   short_update_a: assert property (commit && cnt_q == 5'h03 |=>
      word_q[19:3] == $past(word_q[19:3]) && word_q[2:0] == $past(shift_q[2:0]))
      else $error("short transfer touched upper bits");
   commit_only_a: assert property (word_q != $past(word_q) |-> $past(commit))
      else $error("config changed without close sequence");
   bw_override_a: assert property (loaded_q && clk_en_in ##1 clk_en_in |->
      demod_bw_out == $past(word_q[4:3]))
      else $error("bandwidth not taken from serial word");
   shutdown_dead_a: assert property (pd_hi |=> !operational_out ##1 !data_pin_out)
      else $error("device active in shutdown");
   startup_time_a: assert property (operational_out |->
      low_run_q >= (`RSCP_STARTUP_CW+1)'(STARTUP_CYCLES))
      else $error("data enabled before startup delay");
   autopoll_hold_a: assert property (autopoll_out && !woken_q && clk_en_in
      |=> !data_pin_out)
      else $error("data pin not held low before wake");
   squelch_gate_a: assert property (sq_q && !signal_valid_in && clk_en_in
      |=> !data_pin_out)
      else $error("squelch let noise through");

   full_word_c: cover property (commit && cnt_q == `RSCP_CNT_FULL);
   desense_only_c: cover property (commit && cnt_q == 5'h03);
   wake_c: cover property (autopoll_out && !woken_q ##1 woken_q);
   open_abort_c: cover property (state_q == ST_OPEN_DAT_HI ##1 state_q == ST_IDLE);
endmodule

`default_nettype wire

// ==== rscp_host_model.sv ====
// Host model: bit-bangs the serial clock and the shared data pin
// Assumes the device releases the data pin while the serial clock is high
`timescale 1ns/1ps
`default_nettype none
module rscp_host_model
   import rscp_pkg::*;
(
   input wire logic clk_in,
   input wire logic dev_d_in,
   input wire logic dev_oe_n_in,
   output var logic sclk_out,
   output var logic wire_out,
   output var int clash_out
);
   logic hd = 1'b0;
   logic hoe = 1'b0;
   logic last_q = 1'b0;
   initial sclk_out = 1'b0;
   initial clash_out = 0;
   // Undriven wire toggles so a stale level never passes
   always_comb wire_out = !dev_oe_n_in ? dev_d_in : hoe ? hd : !last_q;
   always @(posedge clk_in) begin
      last_q <= wire_out;
      if (hoe && !dev_oe_n_in) clash_out <= clash_out + 1;
   end
   // One pin phase of four system cycles
   task automatic st(input logic s, input logic d, input logic oe);
      @(posedge clk_in);
      sclk_out <= s;
      hd <= d;
      hoe <= oe;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic send_word(input rscp_word_t x, input int n);
      st(1, 0, 0);
      st(1, 0, 1);
      st(0, 0, 1);
      st(1, 0, 1);
      st(1, 1, 1);
      st(1, 0, 1);
      for (int i = n - 1; i >= 0; i--) begin
         st(0, hd, 1);
         st(0, x[i], 1);
         st(1, x[i], 1);
      end
      // Clock stays high after the last bit so no extra bit is sampled
      st(1, 0, 1);
      st(1, 1, 1);
      st(1, 0, 1);
      // Release the wire as the clock falls; the device drives it again
      st(0, 0, 0);
   endtask
   // Open with data high at the second clock rise
   task automatic abort_open();
      st(1, 0, 0);
      st(1, 0, 1);
      st(0, 0, 1);
      st(0, 1, 1);
      st(1, 1, 1);
      st(1, 0, 0);
      st(0, 0, 0);
   endtask
endmodule
`default_nettype wire

// ==== test_rscp_port.sv ====
// Testbench of the receiver serial configuration port
// Assumes rscp_host_model plays the host on the serial pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_eq(20'(g), 20'(e))
module test_rscp_port;
   import rscp_pkg::*;
   localparam int SU = 20;
   logic clk = 1'b0, rst = 1'b1, pd = 1'b1, bwl = 1'b1, bwh = 1'b0, sq = 1'b0;
   logic rx = 1'b0, vld = 1'b0, sclk, dwire, dout, oe_n, pm, ld, op;
   logic [2:0] des, win, slp;
   logic [1:0] bw, slc, chk;
   logic ap, hbw, sqo, wdo, rso;
   int clash, n_mismatch = 0, checks_done = 0, cyc = 0, cnt, n;
   rscp_word_t w = '0;
   rscp_word_t v;
   bit el = 0, eo = 0, wk = 0;

   rscp_port #(.STARTUP_CYCLES(SU)) i_rscp_port (.clk_sys_in(clk), .reset_in(rst),
      .clk_en_in(1'b1), .sclk_in(sclk), .data_pin_in(dwire), .data_pin_out(dout),
      .data_pin_oe_n_out(oe_n), .power_down_pin_in(pd), .bw_select_lo_in(bwl),
      .bw_select_hi_in(bwh), .squelch_select_in(sq), .rx_data_in(rx),
      .signal_valid_in(vld), .prog_mode_out(pm), .cfg_loaded_out(ld),
      .operational_out(op), .desense_out(des), .demod_bw_out(bw),
      .slice_level_out(slc), .bit_check_out(chk), .window_out(win),
      .sleep_time_out(slp), .autopoll_out(ap), .high_bw_out(hbw),
      .squelch_on_out(sqo), .watchdog_off_out(wdo), .rssi_offset_out(rso));
   rscp_host_model i_rscp_host_model (.clk_in(clk), .dev_d_in(dout),
      .dev_oe_n_in(oe_n), .sclk_out(sclk), .wire_out(dwire), .clash_out(clash));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check_eq(input logic [19:0] g, input logic [19:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_fields();
      `CHK(des, w[2:0]);
      `CHK(bw, el ? w[4:3] : {bwh, bwl});
      `CHK(slc, w[6:5]);
      `CHK(chk, w[8:7]);
      `CHK(win, w[11:9]);
      `CHK(slp, w[14:12]);
      `CHK(ap, w[15]);
      `CHK(hbw, w[16]);
      `CHK(sqo, el ? w[17] : !sq);
      `CHK({rso, wdo}, w[19:18]);
      `CHK({ld, pm}, {el, 1'b0});
   endtask
   task automatic wr(input rscp_word_t x, input int k);
      i_rscp_host_model.send_word(x, k);
      for (int i = 0; i < k; i++) w[i] = x[i];
      el = 1;
      repeat (6) @(posedge clk);
      `CHK(oe_n, 1'b0);
      `CHK(clash, 0);
      chk_fields();
   endtask
   task automatic chk_dout(input logic r, input logic s);
      @(posedge clk);
      rx <= r;
      vld <= s;
      repeat (4) @(posedge clk);
      wk = wk && w[15] && eo;
      if (w[15] && s && eo) wk = 1;
      `CHK(dout, !eo ? 0 : (w[15] && !wk) ? 0 : ((el ? w[17] : !sq) ? r & s : r));
   endtask

   initial begin
      void'($urandom(42670));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk_fields();
      $display("test reset and pin selects done");
      pd <= 1'b0;
      cnt = 0;
      while (op !== 1'b1 && cnt < 100) begin
         @(posedge clk);
         cnt++;
      end
      `CHK(cnt >= SU + 1 && cnt <= SU + 5, 1);
      eo = 1;
      chk_dout(1, 0);
      chk_dout(1, 1);
      $display("test startup and squelch done");
      bwl <= 1'b1;
      bwh <= 1'b1;
      sq <= 1'b1;
      chk_dout(0, 0);
      wr(20'h4C760, 20);
      chk_dout(1, 0);
      chk_dout(1, 1);
      chk_dout(1, 0);
      $display("test autopoll word done");
      wr(20'h00005, 3);
      bwl <= 1'b0;
      bwh <= 1'b0;
      sq <= 1'b0;
      repeat (5) @(posedge clk);
      chk_fields();
      $display("test short word and override done");
      for (int k = 0; k < 6; k++) begin
         v = 20'($urandom);
         n = $urandom_range(20, 1);
         wr(v, n);
      end
      $display("test random words done");
      i_rscp_host_model.abort_open();
      repeat (6) @(posedge clk);
      chk_fields();
      $display("test aborted open done");
      pd <= 1'b1;
      repeat (5) @(posedge clk);
      eo = 0;
      `CHK(op, 1'b0);
      chk_dout(1, 1);
      $display("test shutdown done");
      report_and_stop();
   end
endmodule
`default_nettype wire
